// file: include/power_up_settings_pkg.sv
// Constants for the power-up settings readout block
package power_up_settings_pkg;
  localparam logic [7:0] CMD_READ_FLASH     = 8'hB0;
  localparam logic [7:0] STATUS_OK          = 8'h00;
  localparam int         RSP_BYTES          = 64;
  localparam logic [5:0] RSP_LAST_IDX       = 6'h3F;
  localparam logic [7:0] CHIP_STRUCT_LEN    = 8'h0E;
  localparam logic [7:0] GP_STRUCT_LEN      = 8'h08;
  // Response byte positions
  localparam logic [5:0] IDX_CMD            = 6'h00;
  localparam logic [5:0] IDX_STATUS         = 6'h01;
  localparam logic [5:0] IDX_LEN            = 6'h02;
  localparam logic [5:0] IDX_CHIP_FIRST     = 6'h04;
  localparam logic [5:0] IDX_CHIP_LAST      = 6'h0D;
  localparam logic [5:0] IDX_CHIP_ANALOG    = 6'h07;
  localparam logic [5:0] IDX_VID_LO         = 6'h08;
  localparam logic [5:0] IDX_VID_HI         = 6'h09;
  localparam logic [5:0] IDX_PID_LO         = 6'h0A;
  localparam logic [5:0] IDX_PID_HI         = 6'h0B;
  localparam logic [5:0] IDX_POWER_ATTR     = 6'h0C;
  localparam logic [5:0] IDX_CURRENT        = 6'h0D;
  localparam logic [5:0] IDX_GP_FIRST       = 6'h04;
  localparam logic [5:0] IDX_GP_LAST        = 6'h06;
  // Chip settings byte 4 idle-level bits
  localparam int BIT_IDLE_RX_LED    = 6;
  localparam int BIT_IDLE_TX_LED    = 5;
  localparam int BIT_IDLE_SUSPEND   = 3;
  localparam int BIT_IDLE_USB_CFG   = 2;
  // Chip settings byte 7 bits
  localparam int BIT_NEG_EDGE       = 6;
  localparam int BIT_POS_EDGE       = 5;
  localparam int BIT_ADC_REF_HI     = 4;
  localparam int BIT_ADC_REF_LO     = 3;
  localparam int BIT_DAC_REF_SUPPLY = 2;
  // Pin settings byte bits
  localparam int BIT_PIN_LEVEL      = 4;
  localparam int BIT_PIN_DIR_IN     = 3;
  // Designation codes
  localparam logic [2:0] DES_GPIO       = 3'h0;
  localparam logic [2:0] DES_DEDICATED  = 3'h1;
  localparam logic [2:0] DES_ALT0       = 3'h2;
  localparam logic [2:0] DES_ALT1       = 3'h3;
  localparam logic [2:0] DES_ALT2       = 3'h4;
  // Reset values of the stored image
  localparam logic [7:0] CHIP_BYTE_RST  = 8'h00;
  localparam logic [7:0] GP_BYTE_RST    = 8'h08;
endpackage : power_up_settings_pkg

// file: design/power_up_settings_readout.sv
// Power-up settings store, pin function mux and 64-byte response builder
//
// Overview of operation
// - Falling edge at edge input sets interrupt flag when negative-edge enable set.
// - Rising edge at edge input sets interrupt flag when positive-edge enable set.
// - ADC reference field: 11 4.096V, 10 2.048V, 01 1.024V, 00 off.
// - DAC reference bit: 1 selects supply, 0 selects internal reference.
// - Vendor identifier reported low byte at index 8, high at 9.
// - Product identifier reported low byte at index 10, high at 11.
// - Index 12 holds power attributes used in configuration descriptor.
// - Index 13 is current in 2 mA units; indices 14 to 63 meaningless.
// - Pin response: command echo index 0, success 1, length 2, index 3 unused.
// - Output-configured pins drive stored level from load completion; reset returns all pins to input, level 0.
// - Direction 1 input, 0 output; only for plain general-purpose designation.
// - Pin 0 at index 4: 000 GPIO, 001 suspend, 010 receive LED.
// - Pin 1 at index 5: GPIO, clock, analog input 1, transmit LED, edge detect.
// - Pin 2 at index 6: GPIO, USB-configured, analog input 2, analog output 1.
// - Suspend indicator idles at stored level, inverts while suspended.
// - USB-configured indicator idles at stored level, inverts once configured.
// - UART LEDs idle at stored level, invert while traffic in progress.
`timescale 1ns/1ps
module power_up_settings_readout (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Image load from nonvolatile storage
  input  wire logic       i_load_valid,
  input  wire logic       i_load_gp,
  input  wire logic [5:0] i_load_index,
  input  wire logic [7:0] i_load_data,
  input  wire logic       i_load_done,
  // Runtime level write for GPIO outputs
  input  wire logic       i_gpio_wr,
  input  wire logic [2:0] i_gpio_level,
  // Response request and stream
  input  wire logic       i_req_valid,
  input  wire logic       i_req_gp,
  output logic            o_req_ready,
  output logic            o_rsp_valid,
  input  wire logic       i_rsp_ready,
  output logic [5:0]      o_rsp_index,
  output logic [7:0]      o_rsp_data,
  output logic            o_rsp_last,
  // Device state feeding dedicated functions
  input  wire logic       i_usb_suspend,
  input  wire logic       i_usb_configured,
  input  wire logic       i_uart_rx_active,
  input  wire logic       i_uart_tx_active,
  input  wire logic       i_ref_clock,
  // Pins
  input  wire logic [2:0] i_pin_in,
  output logic [2:0]      o_pin_out,
  output logic [2:0]      o_pin_oe,
  output logic [2:0]      o_pin_analog,
  // Interrupt detection
  input  wire logic       i_int_clear,
  output logic            o_int_flag,
  // Decoded configuration
  output logic [1:0]      o_adc_ref_sel,
  output logic            o_adc_internal_ref_en,
  output logic            o_dac_ref_supply,
  output logic [15:0]     o_usb_vid,
  output logic [15:0]     o_usb_pid,
  output logic [7:0]      o_usb_power_attr,
  output logic [8:0]      o_usb_current_ma
);

  typedef enum logic {
    RSP_IDLE = 1'b0,
    RSP_SEND = 1'b1
  } rsp_state_e;

  logic [7:0]  chip_q [4:13];
  logic [7:0]  gp_q   [4:6];
  logic [2:0]  level_q;
  logic        edge_prev_q;
  logic        int_q;
  logic        int_d;
  rsp_state_e  state_q;
  logic        sel_gp_q;
  logic [5:0]  idx_q;
  logic [7:0]  data_q;
  logic [2:0]  pin_out_q;
  logic [2:0]  pin_oe_q;
  logic [2:0]  pin_analog_q;

  // Byte of a response at a given position
  function automatic logic [7:0] rsp_byte(input logic gp, input logic [5:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx == power_up_settings_pkg::IDX_CMD) begin
      b = power_up_settings_pkg::CMD_READ_FLASH;
    end else if (idx == power_up_settings_pkg::IDX_STATUS) begin
      b = power_up_settings_pkg::STATUS_OK;
    end else if (idx == power_up_settings_pkg::IDX_LEN) begin
      b = gp ? power_up_settings_pkg::GP_STRUCT_LEN : power_up_settings_pkg::CHIP_STRUCT_LEN;
    end else if (gp && idx >= power_up_settings_pkg::IDX_GP_FIRST && idx <= power_up_settings_pkg::IDX_GP_LAST) begin
      b = gp_q[idx];
    end else if (!gp && idx >= power_up_settings_pkg::IDX_CHIP_FIRST
                 && idx <= power_up_settings_pkg::IDX_CHIP_LAST) begin
      b = chip_q[idx];
    end
    // Index 3 and everything past the structure stay zero
    return b;
  endfunction : rsp_byte

  // Image store; out-of-range loads are dropped
  wire load_chip_hit = i_load_valid && !i_load_gp && i_load_index >= power_up_settings_pkg::IDX_CHIP_FIRST
                       && i_load_index <= power_up_settings_pkg::IDX_CHIP_LAST;
  wire load_gp_hit   = i_load_valid && i_load_gp && i_load_index >= power_up_settings_pkg::IDX_GP_FIRST
                       && i_load_index <= power_up_settings_pkg::IDX_GP_LAST;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 4; i <= 13; i++) begin
        chip_q[i] <= power_up_settings_pkg::CHIP_BYTE_RST;
      end
      for (int j = 4; j <= 6; j++) begin
        gp_q[j] <= power_up_settings_pkg::GP_BYTE_RST;
      end
    end else if (load_chip_hit) begin
      chip_q[i_load_index] <= i_load_data;
    end else if (load_gp_hit) begin
      gp_q[i_load_index] <= i_load_data;
    end
  end

  // Decoded stored fields
  wire [7:0] chip_idle   = chip_q[power_up_settings_pkg::IDX_CHIP_FIRST];
  wire [7:0] chip_analog = chip_q[power_up_settings_pkg::IDX_CHIP_ANALOG];
  wire [2:0] des0        = gp_q[4][2:0];
  wire [2:0] des1        = gp_q[5][2:0];
  wire [2:0] des2        = gp_q[6][2:0];
  wire [2:0] stored_level = {gp_q[6][power_up_settings_pkg::BIT_PIN_LEVEL],
                             gp_q[5][power_up_settings_pkg::BIT_PIN_LEVEL],
                             gp_q[4][power_up_settings_pkg::BIT_PIN_LEVEL]};
  wire [2:0] dir_in       = {gp_q[6][power_up_settings_pkg::BIT_PIN_DIR_IN],
                             gp_q[5][power_up_settings_pkg::BIT_PIN_DIR_IN],
                             gp_q[4][power_up_settings_pkg::BIT_PIN_DIR_IN]};

  // Output levels: stored image on load completion, runtime writes afterwards
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_q <= 3'h0;
    end else if (i_load_done) begin
      level_q <= stored_level;
    end else if (i_gpio_wr) begin
      level_q <= i_gpio_level;
    end
  end

  // Indicator levels are the idle bit flipped by the live condition
  wire suspend_ind  = chip_idle[power_up_settings_pkg::BIT_IDLE_SUSPEND] ^ i_usb_suspend;
  wire usb_cfg_ind  = chip_idle[power_up_settings_pkg::BIT_IDLE_USB_CFG] ^ i_usb_configured;
  wire rx_led       = chip_idle[power_up_settings_pkg::BIT_IDLE_RX_LED] ^ i_uart_rx_active;
  wire tx_led       = chip_idle[power_up_settings_pkg::BIT_IDLE_TX_LED] ^ i_uart_tx_active;

  // Pin function mux; unlisted codes leave the pin undriven
  logic [2:0] pin_out_d;
  logic [2:0] pin_oe_d;
  logic [2:0] pin_analog_d;
  always_comb begin
    pin_out_d    = 3'h0;
    pin_oe_d     = 3'h0;
    pin_analog_d = 3'h0;
    unique case (des0) inside
      power_up_settings_pkg::DES_GPIO: begin
        pin_oe_d[0]  = !dir_in[0];
        pin_out_d[0] = level_q[0];
      end
      power_up_settings_pkg::DES_DEDICATED: begin
        pin_oe_d[0]  = 1'b1;
        pin_out_d[0] = suspend_ind;
      end
      power_up_settings_pkg::DES_ALT0: begin
        pin_oe_d[0]  = 1'b1;
        pin_out_d[0] = rx_led;
      end
      default: begin
        pin_oe_d[0]  = 1'b0;
      end
    endcase
    unique case (des1) inside
      power_up_settings_pkg::DES_GPIO: begin
        pin_oe_d[1]  = !dir_in[1];
        pin_out_d[1] = level_q[1];
      end
      power_up_settings_pkg::DES_DEDICATED: begin
        pin_oe_d[1]  = 1'b1;
        pin_out_d[1] = i_ref_clock;
      end
      power_up_settings_pkg::DES_ALT0: begin
        pin_analog_d[1] = 1'b1;
      end
      power_up_settings_pkg::DES_ALT1: begin
        pin_oe_d[1]  = 1'b1;
        pin_out_d[1] = tx_led;
      end
      default: begin
        pin_oe_d[1]  = 1'b0;
      end
    endcase
    unique case (des2) inside
      power_up_settings_pkg::DES_GPIO: begin
        pin_oe_d[2]  = !dir_in[2];
        pin_out_d[2] = level_q[2];
      end
      power_up_settings_pkg::DES_DEDICATED: begin
        pin_oe_d[2]  = 1'b1;
        pin_out_d[2] = usb_cfg_ind;
      end
      power_up_settings_pkg::DES_ALT0, power_up_settings_pkg::DES_ALT1: begin
        pin_analog_d[2] = 1'b1;
      end
      default: begin
        pin_oe_d[2]  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_out_q    <= 3'h0;
      pin_oe_q     <= 3'h0;
      pin_analog_q <= 3'h0;
    end else begin
      pin_out_q    <= pin_out_d;
      pin_oe_q     <= pin_oe_d;
      pin_analog_q <= pin_analog_d;
    end
  end

  // Edge detection only watches pin 1 when it is assigned to that function
  wire edge_armed = (des1 == power_up_settings_pkg::DES_ALT2);
  wire edge_rise  = edge_armed && i_pin_in[1] && !edge_prev_q;
  wire edge_fall  = edge_armed && !i_pin_in[1] && edge_prev_q;
  wire edge_set   = (edge_fall && chip_analog[power_up_settings_pkg::BIT_NEG_EDGE])
                  || (edge_rise && chip_analog[power_up_settings_pkg::BIT_POS_EDGE]);
  // A new edge in the clearing cycle survives the clear
  assign int_d = edge_set || (int_q && !i_int_clear);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edge_prev_q <= 1'b0;
      int_q       <= 1'b0;
    end else begin
      edge_prev_q <= i_pin_in[1];
      int_q       <= int_d;
    end
  end

  // Response stream, one byte per accepted beat
  wire req_take  = (state_q == RSP_IDLE) && i_req_valid;
  wire beat_take = (state_q == RSP_SEND) && i_rsp_ready;
  wire last_beat = (idx_q == power_up_settings_pkg::RSP_LAST_IDX);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q  <= RSP_IDLE;
      sel_gp_q <= 1'b0;
      idx_q    <= 6'h00;
      data_q   <= 8'h00;
    end else begin
      unique case (state_q)
        RSP_IDLE: begin
          if (req_take) begin
            state_q  <= RSP_SEND;
            sel_gp_q <= i_req_gp;
            idx_q    <= 6'h00;
            data_q   <= rsp_byte(i_req_gp, 6'h00);
          end
        end
        RSP_SEND: begin
          if (beat_take && last_beat) begin
            state_q <= RSP_IDLE;
            data_q  <= 8'h00;
          end else if (beat_take) begin
            idx_q  <= idx_q + 6'h01;
            data_q <= rsp_byte(sel_gp_q, idx_q + 6'h01);
          end
        end
      endcase
    end
  end

  assign o_req_ready = (state_q == RSP_IDLE);
  assign o_rsp_valid = (state_q == RSP_SEND);
  assign o_rsp_index = idx_q;
  assign o_rsp_data  = data_q;
  assign o_rsp_last  = (state_q == RSP_SEND) && last_beat;

  assign o_pin_out    = pin_out_q;
  assign o_pin_oe     = pin_oe_q;
  assign o_pin_analog = pin_analog_q;
  assign o_int_flag   = int_q;

  // Configuration views straight from the stored image
  assign o_adc_ref_sel = {chip_analog[power_up_settings_pkg::BIT_ADC_REF_HI],
                          chip_analog[power_up_settings_pkg::BIT_ADC_REF_LO]};
  assign o_adc_internal_ref_en = |o_adc_ref_sel;
  assign o_dac_ref_supply = chip_analog[power_up_settings_pkg::BIT_DAC_REF_SUPPLY];
  assign o_usb_vid = {chip_q[power_up_settings_pkg::IDX_VID_HI], chip_q[power_up_settings_pkg::IDX_VID_LO]};
  assign o_usb_pid = {chip_q[power_up_settings_pkg::IDX_PID_HI], chip_q[power_up_settings_pkg::IDX_PID_LO]};
  assign o_usb_power_attr = chip_q[power_up_settings_pkg::IDX_POWER_ATTR];
  // Doubling is a shift; the 9-bit port holds the full 510 mA range
  assign o_usb_current_ma = {chip_q[power_up_settings_pkg::IDX_CURRENT], 1'b0};

endmodule : power_up_settings_readout

// file: sim/power_up_settings_readout_props.sv
// Checker for the response stream and the decoded settings outputs
`timescale 1ns/1ps
module power_up_settings_readout_props (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_load_valid,
  input  wire logic        i_load_gp,
  input  wire logic [5:0]  i_load_index,
  input  wire logic [7:0]  i_load_data,
  input  wire logic        i_req_valid,
  input  wire logic        o_req_ready,
  input  wire logic        o_rsp_valid,
  input  wire logic [5:0]  o_rsp_index,
  input  wire logic [7:0]  o_rsp_data,
  input  wire logic        o_rsp_last,
  input  wire logic [1:0]  o_adc_ref_sel,
  input  wire logic        o_adc_internal_ref_en,
  input  wire logic [15:0] o_usb_vid,
  input  wire logic [15:0] o_usb_pid,
  input  wire logic [8:0]  o_usb_current_ma
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Chip image loads only; pin image loads must not touch these outputs
  wire logic ld_chip = i_load_valid && !i_load_gp;
  // Reference field of the byte being loaded, kept as a plain signal for $past
  wire logic [1:0] ld_ref = i_load_data[4:3];
  a_first_byte: assert property (o_req_ready && i_req_valid |=> o_rsp_valid && o_rsp_index == 6'h00 && o_rsp_data == 8'hB0)
    else $error("first response byte wrong");
  a_status_byte: assert property (o_rsp_valid && o_rsp_index == 6'h01 |-> o_rsp_data == 8'h00)
    else $error("status byte wrong");
  a_tail_zero: assert property (o_rsp_valid && o_rsp_index > 6'h0D |-> o_rsp_data == 8'h00)
    else $error("tail byte not zero");
  a_last_flag: assert property (o_rsp_last == (o_rsp_valid && o_rsp_index == 6'h3F))
    else $error("last flag misplaced");
  a_vid_low: assert property (ld_chip && i_load_index == 6'h08 |=> o_usb_vid[7:0] == $past(i_load_data))
    else $error("vendor low byte wrong");
  a_pid_high: assert property (ld_chip && i_load_index == 6'h0B |=> o_usb_pid[15:8] == $past(i_load_data))
    else $error("product high byte wrong");
  a_current_ma: assert property (ld_chip && i_load_index == 6'h0D |=> o_usb_current_ma == {$past(i_load_data), 1'b0})
    else $error("current not doubled");
  a_adc_ref_en: assert property (ld_chip && i_load_index == 6'h07 |=> o_adc_ref_sel == $past(ld_ref)
      && o_adc_internal_ref_en == ($past(ld_ref) != 2'h0))
    else $error("reference select or enable mismatch");
endmodule : power_up_settings_readout_props

// file: sim/host_model.sv
// Host side model that accepts response bytes, promptly or with stalls
`timescale 1ns/1ps
module host_model (
  input  wire logic i_clk,
  input  wire logic i_slow,
  output logic      o_ready
);
  // Random stalls exercise the hold of each byte until accepted
  // Ready is only unknown before the first edge, well inside reset
  always @(posedge i_clk) begin
    o_ready <= #1 i_slow ? 1'($urandom_range(1)) : 1'b1;
  end
endmodule : host_model

// file: sim/power_up_settings_readout_bench.sv
// Testbench for the power-up settings readout block
`timescale 1ns/1ps
module power_up_settings_readout_bench;
  logic i_clk = 0, i_rst_n = 0, i_load_valid = 0, i_load_gp = 0, i_load_done = 0, i_gpio_wr = 0;
  logic i_req_valid = 0, i_req_gp = 0, i_int_clear = 0, i_ref_clock = 0, slow = 0;
  logic i_usb_suspend = 0, i_usb_configured = 0, i_uart_rx_active = 0, i_uart_tx_active = 0;
  logic i_rsp_ready, o_req_ready, o_rsp_valid, o_rsp_last, o_int_flag, o_adc_internal_ref_en, o_dac_ref_supply;
  logic [5:0] i_load_index = 0, o_rsp_index;
  logic [7:0] i_load_data = 0, o_rsp_data, o_usb_power_attr;
  logic [2:0] i_gpio_level = 0, i_pin_in = 0, o_pin_out, o_pin_oe, o_pin_analog, lv;
  logic [1:0] o_adc_ref_sel;
  logic [15:0] o_usb_vid, o_usb_pid;
  logic [8:0] o_usb_current_ma;
  logic [7:0] chip [64], gp [64];
  logic [13:0] q [$];
  int checks = 0, bad_count = 0;
  always #2 i_clk = ~i_clk;
  power_up_settings_readout DUT (.*);
  host_model host (.i_clk(i_clk), .i_slow(slow), .o_ready(i_rsp_ready));
  task results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task step;
    @(posedge i_clk);
    #1;
  endtask : step
  task guard(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      results();
    end
  endtask : guard
  // The bench image only keeps indices that the block stores
  task load(input logic g, input logic [5:0] ix, input logic [7:0] d);
    {i_load_valid, i_load_gp, i_load_index, i_load_data} = {1'b1, g, ix, d};
    if (!g && ix inside {[4:13]}) chip[ix] = d;
    if (g && ix inside {[4:6]}) gp[ix] = d;
    step();
  endtask : load
  task automatic req(input logic g);
    int n = 0;
    for (int k = 0; k < 64; k++)
      q.push_back({6'(k), k == 0 ? 8'hB0 : k == 2 ? (g ? 8'h08 : 8'h0E) :
                   (k > 3 && k < (g ? 7 : 14)) ? (g ? gp[k] : chip[k]) : 8'h00});
    {i_req_valid, i_req_gp} = {1'b1, g};
    while (o_req_ready !== 1'b1 && n < 500) begin
      step();
      n++;
    end
    step();
    i_req_valid = 0;
    step();
    guard(n, 500);
  endtask : req
  task automatic drain;
    int n = 0;
    while (q.size() != 0 && n < 3000) begin
      step();
      n++;
    end
    guard(n, 3000);
  endtask : drain
  function automatic logic [2:0] pin_exp(int p, logic l);
    logic [2:0] c = gp[4+p][2:0];
    logic [7:0] s = chip[4];
    if (c == 3'h0) return {1'b0, ~gp[4+p][3], ~gp[4+p][3] & l};
    if (p == 0 && c == 3'h1) return {2'b01, s[3] ^ i_usb_suspend};
    if (p == 0 && c == 3'h2) return {2'b01, s[6] ^ i_uart_rx_active};
    if (p == 1 && c == 3'h1) return {2'b01, i_ref_clock};
    if (p == 1 && c == 3'h3) return {2'b01, s[5] ^ i_uart_tx_active};
    if (p == 2 && c == 3'h1) return {2'b01, s[2] ^ i_usb_configured};
    if ((p == 1 && c == 3'h2) || (p == 2 && (c == 3'h2 || c == 3'h3))) return 3'b100;
    return 3'b000;
  endfunction : pin_exp
  // Sampled mid-cycle, where byte and ready have settled for the next edge
  always @(negedge i_clk) begin
    if (i_rst_n && o_rsp_valid && i_rsp_ready)
      check(32'({o_rsp_index, o_rsp_data}), 32'(q.size() ? q.pop_front() : 14'h3FFF));
  end
  initial begin
    void'($urandom(16532));
    for (int k = 0; k < 64; k++) begin
      chip[k] = 8'h00;
      gp[k] = 8'h08;
    end
    repeat (16) @(posedge i_clk);
    #1 i_rst_n = 1;
    req(0);
    req(1);
    drain();
    check(o_pin_oe, 3'h0);
    slow = 1;
    for (int k = 4; k < 15; k++) load(0, 6'(k), 8'($urandom));
    for (int k = 4; k < 8; k++) load(1, 6'(k), 8'($urandom));
    i_load_valid = 0;
    step();
    check({o_usb_pid, o_usb_vid}, {chip[11], chip[10], chip[9], chip[8]});
    check({o_usb_power_attr, o_usb_current_ma}, {chip[12], chip[13], 1'b0});
    check({o_adc_ref_sel, o_adc_internal_ref_en}, {chip[7][4:3], |chip[7][4:3]});
    check(o_dac_ref_supply, chip[7][2]);
    req(0);
    req(1);
    req(0);
    drain();
    slow = 0;
    // Every designation code on all three pins, with load and runtime levels
    for (int i = 0; i < 16; i++) begin
      load(0, 6'h04, 8'($urandom));
      for (int p = 0; p < 3; p++) load(1, 6'(4 + p), {3'h0, 2'($urandom), 3'(i / 2)});
      i_load_valid = 0;
      i_load_done = 1;
      step();
      i_load_done = 0;
      lv = {gp[6][4], gp[5][4], gp[4][4]};
      if (i % 2) begin
        i_gpio_level = 3'($urandom);
        lv = i_gpio_level;
        i_gpio_wr = 1;
        step();
        i_gpio_wr = 0;
      end
      {i_usb_suspend, i_usb_configured, i_uart_rx_active, i_uart_tx_active, i_ref_clock} = 5'($urandom);
      repeat (3) step();
      for (int p = 0; p < 3; p++)
        check({o_pin_analog[p], o_pin_oe[p], o_pin_oe[p] & o_pin_out[p]}, pin_exp(p, lv[p]));
    end
    load(1, 6'h05, 8'h0C);
    for (int e = 0; e < 8; e++) begin
      load(0, 6'h07, {1'b0, e[2], e[1], 5'h00});
      i_load_valid = 0;
      i_pin_in = {2'($urandom), ~e[0]};
      i_pin_in[1] = ~e[0];
      repeat (2) step();
      i_int_clear = 1;
      step();
      i_int_clear = 0;
      i_pin_in[1] = e[0];
      repeat (3) step();
      check(o_int_flag, e[0] ? e[1] : e[2]);
    end
    // Falling edge in the clearing cycle keeps the flag; the next clear drops it
    i_int_clear = 1;
    i_pin_in[1] = 0;
    step();
    check(o_int_flag, 1'b1);
    step();
    check(o_int_flag, 1'b0);
    i_int_clear = 0;
    // Mid-run reset returns every pin to input and the stream to idle
    i_rst_n = 0;
    step();
    check({o_int_flag, o_rsp_valid, o_req_ready, o_pin_oe, o_pin_analog, o_usb_vid}, 25'h0400000);
    i_rst_n = 1;
    step();
    results();
  end
endmodule : power_up_settings_readout_bench
bind power_up_settings_readout power_up_settings_readout_props props (.*);
